// ==== uemp_phy_ctrl.sv ====
// Top of the USB endpoint-match and PHY-control register block: APB slave,
// endpoint marking on the receive port, line filter, suspend controller,
// PHY configuration pins and a masked interrupt.
// Assumes PHY line state and suspend inputs are asynchronous to clk_in and
// the receive endpoint strobe comes from logic on clk_in.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "uemp_cfg.svh"
module uemp_phy_ctrl
  import uemp_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        rx_ep_valid_in,
  input  wire logic [3:0]  rx_ep_in,
  output logic             rx_valid_out,
  output logic      [4:0]  rx_ep_out,
  input  wire logic [1:0]  phy_line_in,
  input  wire logic        suspend_req_in,
  output logic             phy_suspend_out,
  output logic             wake_out,
  output logic             pulldown_dis_out,
  output logic      [2:0]  phy_config_pins_out,
  output logic      [7:0]  pwr_data_out,
  output logic             pwr_valid_out,
  output logic      [31:0] otg_mask_out,
  output logic             irq_out
);
  logic [15:0] ep_mark_r;
  logic [31:0] otg_mask_r;
  logic [8:0]  pwr_sig_r;
  logic [31:0] phy_ctrl_r;
  logic [`UEMP_IRQ_BITS-1:0] irq_stat_r;
  logic [`UEMP_IRQ_BITS-1:0] irq_mask_r;
  logic [1:0]  line_s1_r;
  logic [1:0]  line_s2_r;
  logic        susp_s1_r;
  logic        susp_s2_r;
  logic [1:0]  line_filt;
  uemp_susp_e  st_r;
  logic        wake_se0;
  logic        wake_k;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_val;
  logic [`UEMP_IRQ_BITS-1:0] irq_evt;

  // Masks write data so reserved bits never store a value.
  function automatic logic [31:0] wmask(input logic [31:0] d,
                                        input logic [31:0] m);
    wmask = d & m;
  endfunction : wmask

  assign wr_en = psel_in & penable_in & pwrite_in;
  assign rd_en = psel_in & ~penable_in & ~pwrite_in;

  // Pins from the PHY are asynchronous: two flops before any logic.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      line_s1_r <= 2'h0;
      line_s2_r <= 2'h0;
      susp_s1_r <= 1'b0;
      susp_s2_r <= 1'b0;
    end else begin
      line_s1_r <= phy_line_in;
      line_s2_r <= line_s1_r;
      susp_s1_r <= suspend_req_in;
      susp_s2_r <= susp_s1_r;
    end
  end

  // Filter depth comes straight from the control register.
  uemp_line_filter u_filt (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .line_in  (line_s2_r),
    .shift_in (phy_ctrl_r[`UEMP_PHY_FILT_HI:`UEMP_PHY_FILT_LO]),
    .line_out (line_filt)
  );

  // Resume causes are only recognised while hardware owns the wake-up.
  assign wake_se0 = (st_r == UEMP_ST_SUSP) &&
                    phy_ctrl_r[`UEMP_PHY_AUTO_RES] &&
                    (line_filt == UEMP_LS_SE0);
  assign wake_k   = (st_r == UEMP_ST_SUSP) &&
                    phy_ctrl_r[`UEMP_PHY_AUTO_RES] &&
                    (line_filt == UEMP_LS_K);

  // Suspend controller; without the auto bit, software reads the filtered
  // line state and releases suspend by dropping its request.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= UEMP_ST_RUN;
    end else begin
      unique case (st_r)
        UEMP_ST_RUN: begin
          if (susp_s2_r) begin
            st_r <= UEMP_ST_SUSP;
          end
        end
        UEMP_ST_SUSP: begin
          if (wake_se0 || wake_k) begin
            st_r <= UEMP_ST_WAKE;
          end else if (!susp_s2_r) begin
            st_r <= UEMP_ST_RUN;
          end
        end
        UEMP_ST_WAKE: begin
          if (!susp_s2_r) begin
            st_r <= UEMP_ST_RUN;
          end
        end
      endcase
    end
  end

  // Plain read-write registers; reserved bits are masked off on write.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ep_mark_r  <= 16'h0000;
      otg_mask_r <= `UEMP_RESET_VALUE;
      pwr_sig_r  <= 9'h000;
      irq_mask_r <= '0;
    end else if (wr_en) begin
      unique case (paddr_in)
        `UEMP_OFF_EP_MARK:
          ep_mark_r <= 16'(wmask(pwdata_in, `UEMP_EP_MARK_MASK));
        `UEMP_OFF_OTG_MASK:
          otg_mask_r <= wmask(pwdata_in, `UEMP_OTG_MASK_MASK);
        `UEMP_OFF_PWR_SIG:
          pwr_sig_r <= 9'(wmask(pwdata_in, `UEMP_PWR_SIG_MASK));
        `UEMP_OFF_IRQ_MASK:
          irq_mask_r <= pwdata_in[`UEMP_IRQ_BITS-1:0];
        default: begin
        end
      endcase
    end
  end

  // PHY control: the two cause flags are set by hardware and win over a
  // clearing write in the same cycle so no wake-up is lost.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phy_ctrl_r <= `UEMP_RESET_VALUE;
    end else begin
      if (wr_en && paddr_in == `UEMP_OFF_PHY_CTRL) begin
        phy_ctrl_r <= wmask(pwdata_in, `UEMP_PHY_CTRL_MASK);
      end
      if (wake_se0) begin
        phy_ctrl_r[`UEMP_PHY_RST_CAUSE] <= 1'b1;
      end
      if (wake_k) begin
        phy_ctrl_r[`UEMP_PHY_RES_CAUSE] <= 1'b1;
      end
    end
  end

  // Interrupt events: SE0 wake, K wake, marked endpoint received.
  assign irq_evt = {rx_ep_valid_in & ep_mark_r[rx_ep_in], wake_k, wake_se0};

  // Sticky status, write one to clear, set wins over clear.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_stat_r <= '0;
    end else if (wr_en && paddr_in == `UEMP_OFF_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~pwdata_in[`UEMP_IRQ_BITS-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr_in)
      `UEMP_OFF_EP_MARK:   rd_val = {16'h0000, ep_mark_r};
      `UEMP_OFF_OTG_MASK:  rd_val = otg_mask_r;
      `UEMP_OFF_PWR_SIG:   rd_val = {23'h000000, pwr_sig_r};
      `UEMP_OFF_PHY_CTRL:  rd_val = phy_ctrl_r;
      `UEMP_OFF_IRQ_STAT:  rd_val = {29'h0, irq_stat_r};
      `UEMP_OFF_IRQ_MASK:  rd_val = {29'h0, irq_mask_r};
      `UEMP_OFF_LINE_STAT: rd_val = {28'h0, line_filt, line_s2_r};
      default:             rd_val = 32'h0000_0000;
    endcase
  end

  // APB answer: data registered in setup, pready high in the access cycle.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= 1'b0;
      if (rd_en) begin
        prdata_out <= rd_val;
      end
    end
  end

  // Receive port: marked endpoints carry the special flag ORed in.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_valid_out <= 1'b0;
      rx_ep_out    <= 5'h00;
    end else begin
      rx_valid_out <= rx_ep_valid_in;
      if (rx_ep_valid_in) begin
        rx_ep_out <= ep_mark_r[rx_ep_in] ?
                     ({1'b0, rx_ep_in} | `UEMP_EP_SPECIAL_OR) :
                     {1'b0, rx_ep_in};
      end
    end
  end

  // Registered outputs follow the control fields, the suspend state and the masked status.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pulldown_dis_out    <= 1'b0;
      phy_config_pins_out <= 3'h0;
      pwr_data_out        <= 8'h00;
      pwr_valid_out       <= 1'b0;
      otg_mask_out        <= 32'h0000_0000;
      phy_suspend_out     <= 1'b0;
      wake_out            <= 1'b0;
      irq_out             <= 1'b0;
    end else begin
      pulldown_dis_out    <= phy_ctrl_r[`UEMP_PHY_PD_DIS];
      phy_config_pins_out <=
        phy_ctrl_r[`UEMP_PHY_CONF_HI:`UEMP_PHY_CONF_LO];
      pwr_data_out        <= pwr_sig_r[7:0];
      pwr_valid_out       <= pwr_sig_r[8];
      otg_mask_out        <= otg_mask_r;
      phy_suspend_out     <= (st_r == UEMP_ST_SUSP);
      wake_out            <= (st_r == UEMP_ST_WAKE);
      irq_out             <= |(irq_stat_r & irq_mask_r);
    end
  end

  chk_ep_special: assert property (@(posedge clk_in) disable iff (rst_in)
    rx_ep_valid_in && ep_mark_r[rx_ep_in]
    |=> rx_ep_out == {1'b1, $past(rx_ep_in)})
    else $error("Marked endpoint left without the special flag.");
  chk_ep_plain: assert property (@(posedge clk_in) disable iff (rst_in)
    rx_ep_valid_in && !ep_mark_r[rx_ep_in]
    |=> rx_ep_out == {1'b0, $past(rx_ep_in)})
    else $error("Unmarked endpoint altered on the receive port.");
  chk_pulldown_pin: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 pulldown_dis_out == $past(phy_ctrl_r[`UEMP_PHY_PD_DIS]))
    else $error("Pulldown disable pin does not follow control bit.");
  chk_se0_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    wake_se0 |=> phy_ctrl_r[`UEMP_PHY_RST_CAUSE])
    else $error("Reset wake cause not recorded.");
  chk_k_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    wake_k |=> phy_ctrl_r[`UEMP_PHY_RES_CAUSE])
    else $error("Resume wake cause not recorded.");
  chk_cause_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    phy_ctrl_r[`UEMP_PHY_RST_CAUSE] &&
    !(wr_en && paddr_in == `UEMP_OFF_PHY_CTRL)
    |=> phy_ctrl_r[`UEMP_PHY_RST_CAUSE])
    else $error("Reset cause flag dropped without a write.");
  chk_auto_wake: assert property (@(posedge clk_in) disable iff (rst_in)
    (wake_se0 || wake_k) |=> ##1 wake_out)
    else $error("Hardware wake not signalled.");
  chk_no_auto: assert property (@(posedge clk_in) disable iff (rst_in)
    !phy_ctrl_r[`UEMP_PHY_AUTO_RES] && st_r == UEMP_ST_SUSP
    |=> st_r != UEMP_ST_WAKE)
    else $error("Hardware wake while software owns resume.");
  chk_conf_pins: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 phy_config_pins_out ==
    $past(phy_ctrl_r[`UEMP_PHY_CONF_HI:`UEMP_PHY_CONF_LO]))
    else $error("Configuration pins do not follow control bits.");
  chk_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    (phy_ctrl_r & ~`UEMP_PHY_CTRL_MASK) == 32'h0000_0000)
    else $error("Reserved control bits became set.");
  chk_reserved_read: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_en && paddr_in == `UEMP_OFF_PWR_SIG
    |=> prdata_out[31:9] == 23'h0)
    else $error("Reserved power word bits read as nonzero.");
  chk_pwr_write: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_en && paddr_in == `UEMP_OFF_PWR_SIG
    |=> ##1 {pwr_valid_out, pwr_data_out} == $past(pwdata_in[8:0], 2))
    else $error("Power signalling word not stored.");

  // Bus answer, the second cause flag and the sticky interrupt status are
  // guarded too, since a lost flag would hide a wake-up from software.
  chk_res_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    phy_ctrl_r[`UEMP_PHY_RES_CAUSE] &&
    !(wr_en && paddr_in == `UEMP_OFF_PHY_CTRL)
    |=> phy_ctrl_r[`UEMP_PHY_RES_CAUSE])
    else $error("Resume cause flag dropped without a write.");
  chk_apb_ready: assert property (@(posedge clk_in) disable iff (rst_in)
    psel_in && !penable_in |=> pready_out && !pslverr_out)
    else $error("Register access not answered in its first access cycle.");
  chk_irq_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    !(wr_en && paddr_in == `UEMP_OFF_IRQ_STAT)
    |=> (irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r))
    else $error("Interrupt status bit dropped without a clearing write.");

  cov_special_ep: cover property (@(posedge clk_in)
    rx_ep_valid_in && ep_mark_r[rx_ep_in]);
  cov_se0_wake: cover property (@(posedge clk_in) wake_se0);
  cov_k_wake: cover property (@(posedge clk_in) wake_k);
  cov_irq: cover property (@(posedge clk_in) irq_out);
  cov_sw_leave: cover property (@(posedge clk_in)
    st_r == UEMP_ST_SUSP && !phy_ctrl_r[`UEMP_PHY_AUTO_RES] && !susp_s2_r);
endmodule : uemp_phy_ctrl

// ==== uemp_cfg.svh ====
// Register offsets, field positions, reset values and timing constants
// for the USB endpoint-match and PHY-control register block.
// Assumes a 32-bit APB slave with byte addresses on word boundaries.
// Functional notes
// - Each of sixteen endpoint bits, when set, makes a received endpoint appear on the receive port ORed with 0x10.
// - PHY-control bit 18 set to one disables the pulldowns on the two designated PHY-side ports, else they stay enabled.
// - An automatic resume caused by SE0 reset signalling sets PHY-control bit 13 until software writes zero to it.
// - An automatic resume caused by K-state signalling sets PHY-control bit 12 until software writes zero to it.
// - A line-state change is passed on only after being stable for two to the power of PHY-control bits 11 to 8 clocks.
// - With PHY-control bit 7 set, the hardware suspend controller detects resume and leaves suspend by itself.
// - PHY-control bits 6 to 4 drive the three PHY configuration pins directly, one bit per pin.
`ifndef UEMP_CFG_SVH
`define UEMP_CFG_SVH

`define UEMP_OFF_EP_MARK    12'h034
`define UEMP_OFF_OTG_MASK   12'h038
`define UEMP_OFF_PWR_SIG    12'h03C
`define UEMP_OFF_PHY_CTRL   12'h040
`define UEMP_OFF_IRQ_STAT   12'h044
`define UEMP_OFF_IRQ_MASK   12'h048
`define UEMP_OFF_LINE_STAT  12'h04C

`define UEMP_EP_MARK_MASK   32'h0000FFFF
`define UEMP_OTG_MASK_MASK  32'hFFFFFFFF
`define UEMP_PWR_SIG_MASK   32'h000001FF
`define UEMP_PHY_CTRL_MASK  32'h00043FF0
`define UEMP_RESET_VALUE    32'h00000000

`define UEMP_PHY_PD_DIS     18
`define UEMP_PHY_RST_CAUSE  13
`define UEMP_PHY_RES_CAUSE  12
`define UEMP_PHY_FILT_HI    11
`define UEMP_PHY_FILT_LO    8
`define UEMP_PHY_AUTO_RES   7
`define UEMP_PHY_CONF_HI    6
`define UEMP_PHY_CONF_LO    4

`define UEMP_EP_SPECIAL_OR  5'h10
`define UEMP_IRQ_BITS       3
`define UEMP_FILT_CNT_W     16

`endif

// ==== uemp_pkg.sv ====
// Types shared by the endpoint-match and PHY-control block.
// Assumes the constants header is included by the users.
package uemp_pkg;
  // USB full-speed line states as seen on the PHY line-state pins.
  typedef enum logic [1:0] {
    UEMP_LS_SE0 = 2'h0,
    UEMP_LS_J   = 2'h1,
    UEMP_LS_K   = 2'h2,
    UEMP_LS_SE1 = 2'h3
  } uemp_line_e;

  // Suspend controller states.
  typedef enum logic [1:0] {
    UEMP_ST_RUN,
    UEMP_ST_SUSP,
    UEMP_ST_WAKE
  } uemp_susp_e;
endpackage : uemp_pkg

// ==== uemp_line_filter.sv ====
// Line-state glitch filter: passes a new line state on only after it has
// stayed unchanged for two to the power of the given shift in clocks.
// Assumes line_in is already synchronised to clk_in.
`timescale 1ns/1ps
`include "uemp_cfg.svh"
module uemp_line_filter
  import uemp_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic [1:0]                 line_in,
  input  wire logic [3:0]                 shift_in,
  output logic      [1:0]                 line_out
);
  logic [1:0]                 cand_r;
  logic [`UEMP_FILT_CNT_W:0]  cnt_r;
  logic [`UEMP_FILT_CNT_W:0]  lim;

  // The shift is at most 15, so the limit always fits in the counter.
  assign lim = (`UEMP_FILT_CNT_W+1)'(1) << shift_in;

  // Count how long the candidate has been stable; restart on any change.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cand_r   <= 2'h0;
      cnt_r    <= '0;
      line_out <= 2'h0;
    end else if (line_in != cand_r) begin
      cand_r <= line_in;
      cnt_r  <= (`UEMP_FILT_CNT_W+1)'(1);
    end else if (cnt_r < lim) begin
      cnt_r <= cnt_r + 1'b1;
    end else begin
      line_out <= cand_r;
    end
  end

  chk_filter_stable: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(line_out) |-> $past(cnt_r) >= $past(lim))
    else $error("Line state passed on before it was stable long enough.");
endmodule : uemp_line_filter

// ==== uemp_phy_model.sv ====
// Behavioural model of the USB PHY line as the block sees it.
// Assumes the bench calls set_line and that clk_in is the block clock.
`timescale 1ns/1ps
module uemp_phy_model (
  input  wire logic       clk_in,
  input  wire logic       pulldown_dis_in,
  input  wire logic [2:0] phy_config_pins_in,
  output logic      [1:0] phy_line_out
);
  // An idle full-speed bus rests at J through the device pull-up.
  initial phy_line_out = 2'h1;

  // The line moves just after an edge and then holds for cyc clocks.
  task automatic set_line(input logic [1:0] s, input int cyc);
    @(posedge clk_in);
    phy_line_out <= s;
    repeat (cyc) @(posedge clk_in);
  endtask : set_line
endmodule : uemp_phy_model

// ==== uemp_phy_ctrl_test.sv ====
// Self-checking bench for the endpoint-match and PHY-control block.
// Assumes the APB slave answers without wait states but waits anyway.
`timescale 1ns/1ps
`include "uemp_cfg.svh"
module uemp_phy_ctrl_test
  import uemp_pkg::*;
();
  logic        clk_in, rst_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, otg_mask_out, rd;
  logic        pready_out, pslverr_out, rx_ep_valid_in, rx_valid_out;
  logic [3:0]  rx_ep_in;
  logic [4:0]  rx_ep_out;
  logic [1:0]  phy_line_in;
  logic        suspend_req_in, phy_suspend_out, wake_out, pulldown_dis_out;
  logic [2:0]  phy_config_pins_out;
  logic [7:0]  pwr_data_out;
  logic        pwr_valid_out, irq_out;
  int          num_errors, check_count;
  localparam logic [15:0] MARK = 16'hA5C3;
  localparam logic [11:0] OFFS [4] = '{`UEMP_OFF_EP_MARK,
    `UEMP_OFF_OTG_MASK, `UEMP_OFF_PWR_SIG, `UEMP_OFF_PHY_CTRL};
  localparam logic [31:0] MSKS [4] = '{`UEMP_EP_MARK_MASK,
    `UEMP_OTG_MASK_MASK, `UEMP_PWR_SIG_MASK, `UEMP_PHY_CTRL_MASK};

  uemp_phy_ctrl dut (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .rx_ep_valid_in, .rx_ep_in, .rx_valid_out, .rx_ep_out, .phy_line_in,
    .suspend_req_in, .phy_suspend_out, .wake_out, .pulldown_dis_out,
    .phy_config_pins_out, .pwr_data_out, .pwr_valid_out, .otg_mask_out,
    .irq_out);
  uemp_phy_model phy (.clk_in, .pulldown_dis_in(pulldown_dis_out),
    .phy_config_pins_in(phy_config_pins_out), .phy_line_out(phy_line_in));

  // A 25 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Comparisons count every check and report each mismatch at once.
  task automatic chk_reg(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_bit(input string nm, input logic e, g);
    chk_reg(nm, {31'h0, e}, {31'h0, g});
  endtask : chk_bit

  // One APB transfer; reading right after an edge sees the sampled values.
  // The wait has no limit of its own: only the watchdog ends a hang.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1);
    chk_reg("pready wait", 32'h1, 32'(n));
    chk_bit("pslverr", 1'b0, pslverr_out);
    rd = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_reg(nm, e, rd);
  endtask : rdc
  // Register-fed outputs lag by a clock, so two edges let them land.
  task automatic settle;
    repeat (2) @(posedge clk_in);
  endtask : settle
  task automatic wait_lvl(input logic sel, input logic v);
    int n;
    n = 0;
    while ((sel ? wake_out : phy_suspend_out) !== v && n < 100) begin
      @(posedge clk_in);
      n++;
    end
  endtask : wait_lvl

  // Reset values, writable masks, reserved bits and register-fed pins.
  task automatic t_regs;
    chk_bit("irq after reset", 1'b0, irq_out);
    foreach (OFFS[i]) begin
      rdc("reset value", OFFS[i], `UEMP_RESET_VALUE);
      wr(OFFS[i], 32'hFFFFFFFF);
      rdc("written value", OFFS[i], MSKS[i]);
    end
    settle;
    chk_bit("pulldown off", 1'b1, pulldown_dis_out);
    chk_reg("config pins", 32'h7, 32'(phy_config_pins_out));
    chk_reg("power word", 32'h1FF, {23'h0, pwr_valid_out, pwr_data_out});
    chk_reg("otg mask", 32'hFFFFFFFF, otg_mask_out);
    wr(12'h100, 32'hFFFFFFFF);
    rdc("unmapped", 12'h100, 32'h0);
    wr(`UEMP_OFF_PHY_CTRL, 32'h50);
    wr(`UEMP_OFF_PWR_SIG, 32'hA5);
    wr(`UEMP_OFF_OTG_MASK, 32'h0);
    settle;
    chk_bit("pulldown on", 1'b0, pulldown_dis_out);
    chk_reg("config pins", 32'h5, 32'(phy_config_pins_out));
    chk_reg("power word", 32'hA5, {23'h0, pwr_valid_out, pwr_data_out});
  endtask : t_regs

  // Every endpoint in turn, marked and unmarked, each pulse one cycle.
  task automatic t_rx;
    wr(`UEMP_OFF_EP_MARK, {16'h0, MARK});
    for (int e = 0; e < 16; e++) begin
      @(posedge clk_in);
      chk_bit("rx pulse", 1'b0, rx_valid_out);
      rx_ep_valid_in <= 1'b1;
      rx_ep_in <= 4'(e);
      @(posedge clk_in);
      rx_ep_valid_in <= 1'b0;
      @(posedge clk_in);
      chk_bit("rx valid", 1'b1, rx_valid_out);
      chk_reg("rx ep", {27'h0, MARK[e], 4'(e)}, 32'(rx_ep_out));
    end
    rdc("marked irq", `UEMP_OFF_IRQ_STAT, 32'h4);
    wr(`UEMP_OFF_IRQ_STAT, 32'h4);
    rdc("marked clear", `UEMP_OFF_IRQ_STAT, 32'h0);
  endtask : t_rx

  // A glitch one clock short of the window must not pass; a longer one does.
  task automatic t_filter;
    wr(`UEMP_OFF_PHY_CTRL, 32'h300);
    phy.set_line(UEMP_LS_J, 20);
    phy.set_line(UEMP_LS_K, 7);
    phy.set_line(UEMP_LS_J, 12);
    rdc("short glitch", `UEMP_OFF_LINE_STAT, 32'h5);
    phy.set_line(UEMP_LS_K, 16);
    rdc("stable change", `UEMP_OFF_LINE_STAT, 32'hA);
    phy.set_line(UEMP_LS_J, 16);
  endtask : t_filter

  // Hardware resume by K and by SE0, with cause bits and the interrupt.
  task automatic t_wake;
    logic [31:0] cause;
    for (int k = 0; k < 2; k++) begin
      cause = k ? 32'h1180 : 32'h2180;
      wr(`UEMP_OFF_PHY_CTRL, 32'h180);
      suspend_req_in <= 1'b1;
      wait_lvl(1'b0, 1'b1);
      chk_bit("no early wake", 1'b0, wake_out);
      phy.set_line(k ? UEMP_LS_K : UEMP_LS_SE0, 2);
      wait_lvl(1'b1, 1'b1);
      chk_bit("hardware wake", 1'b1, wake_out);
      rdc("wake cause", `UEMP_OFF_PHY_CTRL, cause);
      rdc("irq status", `UEMP_OFF_IRQ_STAT, k ? 32'h2 : 32'h1);
      chk_bit("irq masked", 1'b0, irq_out);
      wr(`UEMP_OFF_IRQ_MASK, 32'h7);
      settle;
      chk_bit("irq raised", 1'b1, irq_out);
      suspend_req_in <= 1'b0;
      phy.set_line(UEMP_LS_J, 8);
      wait_lvl(1'b1, 1'b0);
      chk_bit("wake ends", 1'b0, wake_out);
      wr(`UEMP_OFF_IRQ_STAT, 32'h7);
      settle;
      chk_bit("irq cleared", 1'b0, irq_out);
      rdc("cause held", `UEMP_OFF_PHY_CTRL, cause);
      wr(`UEMP_OFF_PHY_CTRL, 32'h180);
      rdc("cause cleared", `UEMP_OFF_PHY_CTRL, 32'h180);
      wr(`UEMP_OFF_IRQ_MASK, 32'h0);
    end
  endtask : t_wake

  // Without hardware resume, software polls the line and leaves suspend.
  task automatic t_poll;
    wr(`UEMP_OFF_PHY_CTRL, 32'h100);
    suspend_req_in <= 1'b1;
    wait_lvl(1'b0, 1'b1);
    phy.set_line(UEMP_LS_K, 30);
    chk_bit("no hardware wake", 1'b0, wake_out);
    rdc("polled line", `UEMP_OFF_LINE_STAT, 32'hA);
    rdc("no cause", `UEMP_OFF_PHY_CTRL, 32'h100);
    suspend_req_in <= 1'b0;
    phy.set_line(UEMP_LS_J, 8);
    wait_lvl(1'b0, 1'b0);
    chk_bit("software leave", 1'b0, phy_suspend_out);
  endtask : t_poll

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // A hang ends the run through the same closing task.
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    report_and_stop;
  end

  // Main sequence after sixteen cycles of reset.
  initial begin
    rst_in = 1'b1;
    {psel_in, penable_in, pwrite_in, rx_ep_valid_in, suspend_req_in} = '0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    rx_ep_in = 4'h0;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_rx;
    t_filter;
    t_wake;
    t_poll;
    report_and_stop;
  end
endmodule : uemp_phy_ctrl_test
